// file: rtl/oxl_pkg.sv
// package: constants and types of the OR/XOR logic unit
package oxl_pkg;
    // ==========================================
    // opcode prefixes: forms with a parallel-enable bit keep only the upper seven bits
    localparam logic [6:0] OP_OR_RR = 7'h15;
    localparam logic [6:0] OP_XOR_RR = 7'h16;
    localparam logic [6:0] OP_XOR_K8 = 7'h0E;
    localparam logic [7:0] OP_OR_K16 = 8'h7E;
    localparam logic [7:0] OP_XOR_K16 = 8'h7F;
    localparam logic [6:0] OP_ACC_ACC_SHIFT_AMOUNT = 7'h08;
    localparam logic [7:0] OP_K16_HI = 8'h7A;
    localparam logic [7:0] OP_OR_K16_CONST_SHIFT_AMOUNT = 8'h73;
    localparam logic [7:0] OP_XOR_K16_CONST_SHIFT_AMOUNT = 8'h74;
    localparam logic [7:0] OP_OR_MEM_K16 = 8'hF5;
    localparam logic [7:0] OP_XOR_MEM_K16 = 8'hF6;
    // sub-codes
    localparam logic [3:0] SUB_ACC_SHIFT_AMOUNT_OR = 4'h1;
    localparam logic [3:0] SUB_ACC_SHIFT_AMOUNT_XOR = 4'h2;
    localparam logic [2:0] SUB_HI_OR = 3'h3;
    localparam logic [2:0] SUB_HI_XOR = 3'h4;
    localparam int HI_SHIFT = 16;
    // ==========================================
    // register bus offsets (byte addresses)
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_ACC_LO = 8'h10;
    localparam logic [7:0] ADDR_ACC_HI = 8'h20;
    localparam logic [7:0] ADDR_TREG = 8'h30;
    localparam logic [7:0] ADDR_AREG = 8'h40;
    // field positions
    localparam int CTRL_M40_BIT = 0;
    localparam int CTRL_COMPAT_BIT = 1;
    localparam int STAT_CARRY_BIT = 0;
    localparam int STAT_BUSY_BIT = 1;
    // reset values
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam logic [39:0] ACC_RESET = 40'h00_0000_0000;
    localparam logic [15:0] REG16_RESET = 16'h0000;
    // ==========================================
    typedef struct packed {
        logic we;
        logic [7:0] addr;
        logic [15:0] data;
    } oxl_mem_wr_t;
    typedef struct packed {
        logic valid;
        logic [31:0] word;
        logic [7:0] rpt_count;
    } oxl_instr_t;
endpackage

// file: rtl/oxl_unit.sv
// module: OR/XOR logic unit with its register file and register bus
`timescale 1ns/1ps
module oxl_unit
    import oxl_pkg::*;
(
    input wire logic i_clk, // 50 MHz core clock
    input wire logic i_sys_rst, // synchronous reset, high
    input wire oxl_instr_t i_instr, // instruction issue
    input wire logic [15:0] i_mem_rdata, // memory operand of current iteration
    input wire logic [7:0] i_addr, // register bus address
    input wire logic [31:0] i_wdata, // register bus write data
    input wire logic i_wr, // register bus write strobe
    input wire logic i_rd, // register bus read strobe
    output logic [31:0] o_rdata, // register bus read data
    output oxl_mem_wr_t o_mem_wr, // memory write-back
    output logic o_busy, // repeat in progress
    output logic o_done, // last iteration finished
    output logic o_illegal // undecoded opcode
);
    // ==========================================
    // state
    logic [39:0] acc [4];
    logic [15:0] treg [4];
    logic [15:0] areg [8];
    logic forty_bit_mode;
    logic legacy_compat_mode;
    logic carry;
    logic [31:0] held_word;
    logic [7:0] rpt_left;

    // ==========================================
    // helpers
    function automatic logic [15:0] rd16(input logic [3:0] f);
        logic [15:0] v;
        v = 16'h0000;
        if (f[3])
            v = areg[f[2:0]];
        else if (f[2])
            v = treg[f[1:0]];
        else
            v = acc[f[1:0]][15:0];
        return v;
    endfunction

    function automatic logic [39:0] rd40(input logic [3:0] f);
        logic [39:0] v;
        v = {24'h00_0000, rd16(f)};
        if (f[3:2] == 2'b00)
            v = acc[f[1:0]];
        return v;
    endfunction

    function automatic logic [39:0] logic_op(input logic [39:0] a, input logic [39:0] b, input logic is_or);
        return is_or ? (a | b) : (a ^ b);
    endfunction

    function automatic logic [39:0] shift40(input logic [39:0] v, input logic [5:0] amt);
        logic [5:0] neg;
        neg = 6'(-amt);
        return amt[5] ? (v >> neg) : (v << amt);
    endfunction

    // ==========================================
    // issue and repeat
    logic exec;
    logic start;
    logic [31:0] w;
    assign start = i_instr.valid && !o_busy;
    assign exec = start || o_busy;
    assign w = o_busy ? held_word : i_instr.word;

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_busy <= 1'b0;
            rpt_left <= 8'h00;
            held_word <= 32'h0000_0000;
        end else if (start && i_instr.rpt_count != 8'h00) begin
            o_busy <= 1'b1;
            rpt_left <= i_instr.rpt_count;
            held_word <= i_instr.word;
        end else if (o_busy) begin
            rpt_left <= rpt_left - 8'h01;
            o_busy <= (rpt_left != 8'h01);
        end
    end

    // ==========================================
    // decode and compute
    logic [7:0] op;
    logic [1:0] sd_src;
    logic [1:0] sd_dst;
    logic [39:0] src_ext;
    logic [39:0] k16_ext;
    assign op = w[31:24];
    assign sd_src = w[7:6];
    assign sd_dst = w[5:4];
    assign k16_ext = {24'h00_0000, w[23:8]};
    assign src_ext = (forty_bit_mode || legacy_compat_mode) ? acc[sd_src] : {8'h00, acc[sd_src][31:0]};

    logic gen;
    logic gen_or;
    logic gen_rr;
    logic [3:0] gen_dst;
    logic [3:0] gen_src;
    logic [15:0] gen_k;
    logic acc_we;
    logic [1:0] acc_idx;
    logic [39:0] next_acc;
    logic r16_we;
    logic [3:0] r16_idx;
    logic [15:0] next_r16;
    logic legal;
    logic mem_op;
    logic [15:0] next_mem;
    logic [39:0] opnd_a;
    logic [39:0] opnd_b;

    always_comb begin
        gen = 1'b0;
        gen_or = 1'b0;
        gen_rr = 1'b0;
        gen_dst = 4'h0;
        gen_src = 4'h0;
        gen_k = 16'h0000;
        acc_we = 1'b0;
        acc_idx = sd_dst;
        next_acc = ACC_RESET;
        r16_we = 1'b0;
        r16_idx = 4'h0;
        next_r16 = REG16_RESET;
        legal = 1'b1;
        mem_op = 1'b0;
        next_mem = 16'h0000;
        opnd_a = ACC_RESET;
        opnd_b = ACC_RESET;
        case (op)
            OP_OR_K16, OP_XOR_K16: begin
                gen = 1'b1;
                gen_or = (op == OP_OR_K16);
                gen_k = w[23:8];
                gen_dst = w[7:4];
                gen_src = w[3:0];
            end
            OP_K16_HI: begin
                acc_we = (w[3:1] == SUB_HI_OR) || (w[3:1] == SUB_HI_XOR);
                legal = acc_we;
                next_acc = logic_op(acc[sd_src], k16_ext << HI_SHIFT, w[3:1] == SUB_HI_OR);
            end
            OP_OR_K16_CONST_SHIFT_AMOUNT, OP_XOR_K16_CONST_SHIFT_AMOUNT: begin
                acc_we = 1'b1;
                next_acc = logic_op(src_ext, k16_ext << w[3:0], op == OP_OR_K16_CONST_SHIFT_AMOUNT);
            end
            OP_OR_MEM_K16, OP_XOR_MEM_K16: begin
                mem_op = 1'b1;
                next_mem = (op == OP_OR_MEM_K16) ? (i_mem_rdata | w[15:0]) : (i_mem_rdata ^ w[15:0]);
            end
            default: begin
                // forms whose lowest opcode bit is the parallel-enable bit
                case (op[7:1])
                    OP_OR_RR, OP_XOR_RR: begin
                        gen = 1'b1;
                        gen_or = (op[7:1] == OP_OR_RR);
                        gen_rr = 1'b1;
                        gen_src = w[23:20];
                        gen_dst = w[19:16];
                    end
                    OP_XOR_K8: begin
                        gen = 1'b1;
                        gen_k = {8'h00, w[23:16]};
                        gen_dst = w[15:12];
                        gen_src = w[11:8];
                    end
                    OP_ACC_ACC_SHIFT_AMOUNT: begin
                        acc_idx = w[23:22];
                        acc_we = (w[19:16] == SUB_ACC_SHIFT_AMOUNT_OR) || (w[19:16] == SUB_ACC_SHIFT_AMOUNT_XOR);
                        legal = acc_we;
                        opnd_a = (forty_bit_mode || legacy_compat_mode) ? acc[w[21:20]]
                                                                         : {8'h00, acc[w[21:20]][31:0]};
                        next_acc = logic_op(acc[w[23:22]], shift40(opnd_a, w[13:8]), w[19:16] == SUB_ACC_SHIFT_AMOUNT_OR);
                    end
                    default: begin
                        legal = 1'b0;
                    end
                endcase
            end
        endcase
        if (gen) begin
            if (gen_dst[3:2] == 2'b00) begin
                acc_we = 1'b1;
                acc_idx = gen_dst[1:0];
                opnd_a = rd40(gen_src);
                opnd_b = gen_rr ? rd40(gen_dst) : {24'h00_0000, gen_k};
                next_acc = logic_op(opnd_a, opnd_b, gen_or);
            end else begin
                r16_we = 1'b1;
                r16_idx = gen_dst;
                opnd_a = {24'h00_0000, rd16(gen_src)};
                opnd_b = {24'h00_0000, gen_rr ? rd16(gen_dst) : gen_k};
                next_r16 = 16'(logic_op(opnd_a, opnd_b, gen_or));
            end
        end
    end

    // ==========================================
    // register file: execution wins over a bus write in the same cycle
    logic bus_acc_lo;
    logic bus_acc_hi;
    logic bus_treg;
    logic bus_areg;
    assign bus_acc_lo = i_wr && (i_addr[7:4] == ADDR_ACC_LO[7:4]);
    assign bus_acc_hi = i_wr && (i_addr[7:4] == ADDR_ACC_HI[7:4]);
    assign bus_treg = i_wr && (i_addr[7:4] == ADDR_TREG[7:4]);
    assign bus_areg = i_wr && (i_addr[7:5] == ADDR_AREG[7:5]);

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            for (int i = 0; i < 4; i++) begin
                acc[i] <= ACC_RESET;
                treg[i] <= REG16_RESET;
            end
            for (int i = 0; i < 8; i++) begin
                areg[i] <= REG16_RESET;
            end
        end else begin
            if (bus_acc_lo)
                acc[i_addr[3:2]][31:0] <= i_wdata;
            if (bus_acc_hi)
                acc[i_addr[3:2]][39:32] <= i_wdata[7:0];
            if (bus_treg)
                treg[i_addr[3:2]] <= i_wdata[15:0];
            if (bus_areg)
                areg[i_addr[4:2]] <= i_wdata[15:0];
            if (exec && acc_we)
                acc[acc_idx] <= next_acc;
            if (exec && r16_we && r16_idx[3])
                areg[r16_idx[2:0]] <= next_r16;
            else if (exec && r16_we)
                treg[r16_idx[1:0]] <= next_r16;
        end
    end

    // ==========================================
    // mode and status bits (software only)
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            forty_bit_mode <= CTRL_RESET[CTRL_M40_BIT];
            legacy_compat_mode <= CTRL_RESET[CTRL_COMPAT_BIT];
            carry <= 1'b0;
        end else if (i_wr && i_addr == ADDR_CTRL) begin
            forty_bit_mode <= i_wdata[CTRL_M40_BIT];
            legacy_compat_mode <= i_wdata[CTRL_COMPAT_BIT];
        end else if (i_wr && i_addr == ADDR_STATUS) begin
            carry <= i_wdata[STAT_CARRY_BIT];
        end
    end

    // ==========================================
    // outputs
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_mem_wr <= '0;
            o_done <= 1'b0;
            o_illegal <= 1'b0;
        end else begin
            o_mem_wr.we <= exec && mem_op;
            o_mem_wr.addr <= w[23:16];
            o_mem_wr.data <= next_mem;
            o_done <= exec && legal && (o_busy ? (rpt_left == 8'h01) : (i_instr.rpt_count == 8'h00));
            o_illegal <= exec && !legal;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_rdata <= 32'h0000_0000;
        end else if (i_rd) begin
            case (i_addr[7:4])
                ADDR_CTRL[7:4]: begin
                    if (i_addr[3:2] == 2'b00)
                        o_rdata <= {30'h0, legacy_compat_mode, forty_bit_mode};
                    else if (i_addr[3:2] == 2'b01)
                        o_rdata <= {30'h0, o_busy, carry};
                    else
                        o_rdata <= 32'h0000_0000;
                end
                ADDR_ACC_LO[7:4]: o_rdata <= acc[i_addr[3:2]][31:0];
                ADDR_ACC_HI[7:4]: o_rdata <= {24'h00_0000, acc[i_addr[3:2]][39:32]};
                ADDR_TREG[7:4]: o_rdata <= {16'h0000, treg[i_addr[3:2]]};
                4'h4, 4'h5: o_rdata <= {16'h0000, areg[i_addr[4:2]]};
                default: o_rdata <= 32'h0000_0000;
            endcase
        end
    end

    // ==========================================
    // assertions
    sequence s_issue_single;
        start && i_instr.rpt_count == 8'h00 && legal;
    endsequence

    a_done_one_cycle: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        s_issue_single |=> o_done)
        else $error("single instruction did not finish in one cycle");

    a_carry_kept: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        exec && !(i_wr && i_addr == ADDR_STATUS) |=> $stable(carry))
        else $error("carry changed by a logical instruction");

    a_mem_or_result: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        exec && op == OP_OR_MEM_K16 |=> o_mem_wr.we && o_mem_wr.data == ($past(i_mem_rdata) | $past(w[15:0])))
        else $error("memory OR result wrong");

    a_mem_xor_result: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        exec && op == OP_XOR_MEM_K16 |=> o_mem_wr.we && o_mem_wr.data == ($past(i_mem_rdata) ^ $past(w[15:0])))
        else $error("memory XOR result wrong");

    a_k16_const_shift_amount_ext: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        exec && op == OP_OR_K16_CONST_SHIFT_AMOUNT && !forty_bit_mode && !legacy_compat_mode && w[3:0] < 4'h8
        |-> next_acc[39:32] == 8'h00)
        else $error("source not zero-extended in 32-bit mode");

    a_hi_xor_value: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        exec && op == OP_K16_HI && w[3:1] == SUB_HI_XOR
        |-> next_acc == (acc[sd_src] ^ {8'h00, w[23:8], 16'h0000}))
        else $error("k16 high XOR wrong");

    a_r16_no_acc: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        exec && gen && gen_dst[3:2] != 2'b00 |-> r16_we && !acc_we)
        else $error("16-bit destination routed to accumulator");

    a_repeat_span: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        start && legal && i_instr.rpt_count == 8'h02 |=> o_busy ##1 o_busy ##1 (!o_busy && o_done))
        else $error("repeat did not run count plus one iterations");

    a_illegal_flag: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        exec && !legal |=> o_illegal && !o_mem_wr.we)
        else $error("undecoded opcode not flagged");
endmodule // oxl_unit

// file: testbench/oxl_unit_bench.sv
// self-checking bench for the OR/XOR logic unit
`timescale 1ns/1ps
module oxl_unit_bench;
    import oxl_pkg::*;
    // ==========================================
    // signals
    typedef struct packed {
        logic [31:0] word;
        logic [7:0] raddr;
        logic [39:0] exp;
    } oxl_row_t;
    logic i_clk;
    logic i_sys_rst;
    oxl_instr_t i_instr;
    logic [15:0] i_mem_rdata;
    logic [7:0] i_addr;
    logic [31:0] i_wdata;
    logic i_wr;
    logic i_rd;
    logic [31:0] o_rdata;
    oxl_mem_wr_t o_mem_wr;
    logic o_busy;
    logic o_done;
    logic o_illegal;
    int n_mismatch;
    int n_compared;
    int n_cycles;
    int n_wb;
    logic [15:0] wb_data;
    logic [7:0] wb_addr;
    logic busy_seen;
    logic [39:0] rv;
    logic [31:0] d;
    oxl_row_t rows [12];

    oxl_unit dut (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_instr(i_instr),
        .i_mem_rdata(i_mem_rdata),
        .i_addr(i_addr),
        .i_wdata(i_wdata),
        .i_wr(i_wr),
        .i_rd(i_rd),
        .o_rdata(o_rdata),
        .o_mem_wr(o_mem_wr),
        .o_busy(o_busy),
        .o_done(o_done),
        .o_illegal(o_illegal)
    );

    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end

    // ==========================================
    // helpers
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    always @(posedge i_clk) begin
        n_cycles = n_cycles + 1;
        if (n_cycles == 20000) begin
            n_mismatch = n_mismatch + 1;
            close_out();
        end
    end

    task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= v;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask

    task automatic bus_rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        v = o_rdata;
    endtask

    task automatic get_reg(input logic [7:0] a, output logic [39:0] v);
        logic [31:0] lo;
        logic [31:0] hi;
        bus_rd(a, lo);
        if (a < ADDR_TREG) begin
            bus_rd(a + 8'h10, hi);
            v = {hi[7:0], lo};
        end else begin
            v = {24'h0, lo[15:0]};
        end
    endtask

    task automatic preload();
        bus_wr(ADDR_ACC_LO, 32'h2355_4FC0);
        bus_wr(ADDR_ACC_HI, 32'h0000_007E);
        bus_wr(ADDR_ACC_LO + 8'h04, 32'hE340_5678);
        bus_wr(ADDR_ACC_HI + 8'h04, 32'h0000_000F);
        bus_wr(ADDR_TREG, 32'h0000_1234);
        bus_wr(ADDR_AREG + 8'h08, 32'h0000_ABCD);
    endtask

    task automatic launch(input logic [31:0] w, input logic [7:0] rpt);
        @(posedge i_clk);
        i_instr <= '{valid: 1'b1, word: w, rpt_count: rpt};
    endtask

    task automatic wait_done();
        int k;
        @(posedge i_clk);
        i_instr.valid <= 1'b0;
        n_wb = 0;
        busy_seen = 1'b0;
        for (k = 0; k < 300; k++) begin
            #1;
            if (o_busy === 1'b1) busy_seen = 1'b1;
            if (o_mem_wr.we === 1'b1) begin
                n_wb++;
                wb_data = o_mem_wr.data;
                wb_addr = o_mem_wr.addr;
            end
            if (o_done === 1'b1) break;
            @(posedge i_clk);
        end
        if (k == 300) check("done", 40'h0, 40'h1);
    endtask

    // ==========================================
    // main sequence
    initial begin
        n_mismatch = 0;
        n_compared = 0;
        n_cycles = 0;
        i_sys_rst = 1'b1;
        i_instr = '0;
        i_mem_rdata = 16'h0000;
        i_addr = 8'h00;
        i_wdata = 32'h0;
        i_wr = 1'b0;
        i_rd = 1'b0;
        rows[0] = '{32'h2C01_0000, ADDR_ACC_LO + 8'h04, 40'h71_C015_19B8};
        rows[1] = '{32'h2C41_0000, ADDR_ACC_LO + 8'h04, 40'h0F_E340_444C};
        rows[2] = '{32'h2C0A_0000, ADDR_AREG + 8'h08, 40'h00_0000_E40D};
        rows[3] = '{32'h1CFF_0100, ADDR_ACC_LO, 40'h0F_E340_5687};
        rows[4] = '{32'h7FFF_FF01, ADDR_ACC_LO, 40'h0F_E340_A987};
        rows[5] = '{32'h7F00_FF50, ADDR_TREG + 8'h04, 40'h00_0000_4F3F};
        rows[6] = '{32'h730F_FF4F, ADDR_ACC_LO, 40'h00_E7FF_D678};
        rows[7] = '{32'h7AFF_FF68, ADDR_ACC_LO + 8'h08, 40'h0F_1CBF_5678};
        rows[8] = '{32'h7AFF_FF66, ADDR_ACC_LO + 8'h08, 40'h0F_FFFF_5678};
        rows[9] = '{32'h74FF_FF30, ADDR_ACC_LO + 8'h0C, 40'h00_2355_B03F};
        rows[10] = '{32'h1041_0400, ADDR_ACC_LO + 8'h04, 40'h0F_F754_FE78};
        rows[11] = '{32'h1042_0400, ADDR_ACC_LO + 8'h04, 40'h0D_D614_AA78};
        repeat (2) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        bus_rd(ADDR_CTRL, d);
        check("ctrl reset", {8'h0, d}, 40'h0);
        get_reg(ADDR_ACC_LO, rv);
        check("acc reset", rv, 40'h0);
        bus_rd(8'hFC, d);
        check("unmapped", {8'h0, d}, 40'h0);
        for (int i = 0; i < 12; i++) begin
            preload();
            launch(rows[i].word, 8'h00);
            wait_done();
            get_reg(rows[i].raddr, rv);
            check($sformatf("row %0d", i), rv, rows[i].exp);
        end
        // wide modes keep the upper accumulator bits
        for (int m = 1; m < 3; m++) begin
            preload();
            bus_wr(ADDR_CTRL, 32'(m));
            launch(32'h74FF_FF30, 8'h00);
            wait_done();
            get_reg(ADDR_ACC_LO + 8'h0C, rv);
            check("wide mode", rv, 40'h7E_2355_B03F);
        end
        bus_wr(ADDR_CTRL, 32'h0);
        bus_wr(ADDR_STATUS, 32'h1);
        launch(32'h730F_FF4F, 8'h00);
        wait_done();
        bus_rd(ADDR_STATUS, d);
        check("carry kept", {39'h0, d[STAT_CARRY_BIT]}, 40'h1);
        i_mem_rdata <= 16'h5678;
        launch(32'hF512_0FC0, 8'h02);
        wait_done();
        check("wb count", 40'(n_wb), 40'h3);
        check("wb addr", {32'h0, wb_addr}, 40'h12);
        check("wb data", {24'h0, wb_data}, 40'h5FF8);
        check("busy seen", {39'h0, busy_seen}, 40'h1);
        launch(32'hF634_FFFF, 8'h00);
        wait_done();
        check("xor wb", {24'h0, wb_data}, 40'hA987);
        preload();
        launch(32'h2C01_0000, 8'h01);
        wait_done();
        get_reg(ADDR_ACC_LO + 8'h04, rv);
        check("repeat rr", rv, 40'h0F_E340_5678);
        preload();
        launch(32'h2C01_0000, 8'h00);
        launch(32'h7AFF_FF68, 8'h00);
        wait_done();
        get_reg(ADDR_ACC_LO + 8'h08, rv);
        check("dependent", rv, 40'h71_3FEA_19B8);
        // undecoded opcode: flagged, never reported as done
        launch(32'h0000_0000, 8'h00);
        @(posedge i_clk);
        i_instr.valid <= 1'b0;
        #1;
        check("illegal", {39'h0, o_illegal}, 40'h1);
        check("illegal done", {39'h0, o_done}, 40'h0);
        check("illegal wb", {39'h0, o_mem_wr.we}, 40'h0);
        // reset in mid-run clears modes and registers
        bus_wr(ADDR_CTRL, 32'h3);
        @(posedge i_clk);
        i_sys_rst <= 1'b1;
        @(posedge i_clk);
        i_sys_rst <= 1'b0;
        bus_rd(ADDR_CTRL, d);
        check("ctrl after reset", {8'h0, d}, 40'h0);
        get_reg(ADDR_ACC_LO + 8'h04, rv);
        check("acc after reset", rv, 40'h0);
        close_out();
    end
endmodule // oxl_unit_bench
